// >>> bench/mspp_assertions.sv
// Concurrent checks on the ports of the protection block.
`timescale 1ns/10ps
`default_nettype none
module mspp_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [15:0] fund_current,
  input wire logic [7:0] neg_pos_sequence_ratio,
  input wire logic motor_starting,
  input wire logic pr_start,
  input wire logic pr_trip,
  input wire logic stall_start,
  input wire logic stall_trip
);
  // ==========================================================
  // Checks, all in the one clock domain.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  wire pr_cond;
  assign pr_cond = motor_starting && neg_pos_sequence_ratio > 8'h50 && fund_current > 16'h0014;
  ok_resp_a: assert property (!hresp) else $error("bus response not okay");
  bus_wait_a: assert property (hsel && htrans[1] && hready && hreadyout |=> !hreadyout ##1 hreadyout)
    else $error("bus wait state wrong");
  pr_start_a: assert property (pr_cond |=> pr_start) else $error("reversal start missing");
  pr_cause_a: assert property ($rose(pr_start) |-> $past(pr_cond)) else $error("reversal start uncaused");
  pr_hold_a: assert property ($rose(pr_start) |-> !pr_trip [*8]) else $error("reversal trip too early");
  pr_trip_a: assert property (pr_trip |-> pr_start) else $error("reversal trip without start");
  stall_idle_a: assert property (!motor_starting |=> !stall_start && !stall_trip)
    else $error("stall active while not starting");
  stall_rel_a: assert property (fund_current < 16'h0078 |=> !stall_start) else $error("stall not released");
  stall_trip_a: assert property ($rose(stall_trip) |-> stall_start) else $error("stall trip without start");
  // Main scenarios reached.
  pr_trip_c: cover property ($rose(pr_trip));
  stall_trip_c: cover property ($rose(stall_trip));
  bus_xfer_c: cover property (hsel && htrans[1] && hreadyout);
endmodule // mspp_checker
`default_nettype wire

// >>> bench/mspp_meas_model.sv
// Measurement path and fault recorder model feeding the protection block.
`timescale 1ns/10ps
`default_nettype none
module mspp_meas_model (
  input wire logic mclk,
  output logic [15:0] fund_current,
  output logic [7:0] neg_pos_sequence_ratio,
  output logic motor_starting,
  output logic unb_fault,
  output logic [15:0] unb_peak,
  output logic [6:0] unb_elapsed_delay_pct,
  output logic active_setting_group,
  output logic [31:0] rtc_date,
  output logic [26:0] rtc_time
);
  // ==========================================================
  // Quiet path at start, a stopped motor.
  initial begin
    {fund_current, neg_pos_sequence_ratio, motor_starting, unb_fault} = '0;
    {unb_peak, unb_elapsed_delay_pct, active_setting_group} = '0;
    rtc_date = 32'h07d00101;
    rtc_time = 27'h0;
  end
  // New measurement, levels change just after an edge.
  // Starting currents used range from 5 to 700 hundredths, either side of the detection level.
  task meas(input logic [15:0] c, input logic [7:0] r, input logic s);
    @(posedge mclk);
    fund_current <= c;
    neg_pos_sequence_ratio <= r;
    motor_starting <= s;
  endtask
  // One-cycle fault pulse; peak and delay lines are scrambled once it is gone.
  task fault(input logic [15:0] pk, input logic [6:0] ed, input logic g, output logic [58:0] st);
    @(posedge mclk);
    unb_fault <= 1'b1;
    unb_peak <= pk;
    unb_elapsed_delay_pct <= ed;
    active_setting_group <= g;
    rtc_time <= rtc_time + 27'h401;
    st = {rtc_date, rtc_time + 27'h401};
    @(posedge mclk);
    unb_fault <= 1'b0;
    unb_peak <= ~pk;
    unb_elapsed_delay_pct <= ~ed;
  endtask
endmodule // mspp_meas_model
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the motor stall and phase sequence block.
`timescale 1ns/10ps
`default_nettype none
`include "mspp_defs.vh"
module testbench;
  logic mclk, reset, hsel, hwrite, panel_button;
  logic [31:0] haddr, hwdata, rdat;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] lf;
  logic [6:0] ed;
  logic [58:0] st;
  logic [82:0] q[$];
  wire [31:0] hrdata, rtc_date;
  wire hreadyout, hresp, pr_start, pr_trip, stall_start, stall_trip, test_force, irq;
  wire motor_starting, unb_fault, active_setting_group;
  wire [15:0] fund_current, unb_peak;
  wire [7:0] neg_pos_sequence_ratio;
  wire [6:0] unb_elapsed_delay_pct;
  wire [26:0] rtc_time;
  int miscompares, n_tests, n, i;
  // ==========================================================
  // Design and far side; times shortened by the parameters.
  mspp_top #(.P_MS_CYCLES(14'd4), .P_PR_MS(16'd5), .P_WIN_MS(16'd10), .P_FORCE_MS(19'd20)) DUT (
    .mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .fund_current(fund_current), .neg_pos_sequence_ratio(neg_pos_sequence_ratio),
    .motor_starting(motor_starting), .panel_button(panel_button), .unb_fault(unb_fault),
    .unb_peak(unb_peak), .unb_elapsed_delay_pct(unb_elapsed_delay_pct), .active_setting_group(active_setting_group),
    .rtc_date(rtc_date), .rtc_time(rtc_time), .pr_start(pr_start), .pr_trip(pr_trip),
    .stall_start(stall_start), .stall_trip(stall_trip), .test_force(test_force), .irq(irq));
  mspp_meas_model u_meas (.mclk(mclk), .fund_current(fund_current),
    .neg_pos_sequence_ratio(neg_pos_sequence_ratio), .motor_starting(motor_starting),
    .unb_fault(unb_fault), .unb_peak(unb_peak), .unb_elapsed_delay_pct(unb_elapsed_delay_pct),
    .active_setting_group(active_setting_group), .rtc_date(rtc_date), .rtc_time(rtc_time));
  // ==========================================================
  // Clock and helpers.
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One AHB-Lite single transfer; waits on hready, data taken at the end.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge mclk);
    while (!hreadyout) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (!hreadyout) @(posedge mclk);
    rdat = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register", rdat, e);
  endtask
  task hold(input logic [15:0] c, input logic [7:0] r, input logic s, input int k);
    u_meas.meas(c, r, s);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  // Count cycles until a trip output rises, bounded.
  task wait_trip(input logic stall);
    n = 0;
    while (!(stall ? stall_trip : pr_trip) && n < 200) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask
  task stop_test;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog; the whole run needs well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    stop_test;
  end
  // ==========================================================
  // Main sequence.
  initial begin
    reset = 1'b1;
    {hsel, hwrite, panel_button, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    lf = 16'd54691;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    rc(`MSPP_A_RSTART, 32'h258);
    rc(`MSPP_A_STDETA, 32'h12c);
    wr(`MSPP_A_MOTNOM, 32'hc8);
    rc(`MSPP_A_STDETA, 32'h258);
    rc(8'h7c, 32'h0);
    wr(`MSPP_A_MASK, 32'h1);
    // Reversal: boundaries refused, then a real start and trip.
    hold(50, 80, 1, 6); chk("pr_start", pr_start, 0);
    hold(20, 90, 1, 6); chk("pr_start", pr_start, 0);
    hold(50, 90, 0, 6); chk("pr_start", pr_start, 0);
    hold(50, 90, 1, 2); chk("pr_start", pr_start, 1);
    // The interrupt follows its status bit by one cycle.
    @(posedge mclk);
    #1;
    chk("irq", irq, 1);
    wait_trip(1'b0); chk("pr_delay", n >= 14 && n <= 22, 1);
    rc(`MSPP_A_ELAPSED_DELAY_PCT, 32'h64);
    hold(50, 0, 1, 2); hold(50, 90, 1, 3); hold(50, 0, 1, 2);
    rc(`MSPP_A_PRCNT, 32'h00010002);
    wr(`MSPP_A_STAT, 32'h1f); repeat (2) @(posedge mclk); #1; chk("irq", irq, 0);
    // Stall, definite time: expired window, then a genuine start.
    wr(`MSPP_A_TDEF, 32'h3);
    hold(5, 0, 1, 3); hold(100, 0, 1, 60); hold(700, 0, 1, 5); chk("stall_start", stall_start, 0);
    hold(5, 0, 1, 3); hold(700, 0, 1, 3); chk("stall_start", stall_start, 1);
    wait_trip(1'b1); chk("stall_dt", n >= 8 && n <= 14, 1);
    // With a four-cycle millisecond the percent lags the timer; let it settle first.
    repeat (120) @(posedge mclk);
    bus(1'b0, `MSPP_A_ELAPSED_DELAY_PCT, 32'h0);
    chk("stall_elapsed_delay_pct", rdat[22:16], 32'h64);
    hold(100, 0, 1, 2); chk("stall_rel", {stall_start, stall_trip}, 0);
    rc(`MSPP_A_STCNT, 32'h00010001);
    hold(5, 0, 0, 3); hold(700, 0, 0, 4); chk("stall_idle", stall_start, 0);
    // Inverse time: 2 ms times (600/400) squared is 4.5 ms.
    wr(`MSPP_A_CTRL, 32'h1); wr(`MSPP_A_INVERSE_TIME_MULTIPLIER, 32'h2);
    hold(5, 0, 1, 3); hold(400, 0, 1, 0);
    wait_trip(1'b1); chk("stall_inv", n >= 14 && n <= 26, 1);
    hold(100, 0, 1, 2);
    // Fault log: nine random records, the oldest must fall out.
    for (i = 0; i < 9; i++) begin
      lf = lfsr(lf);
      ed = lf[6:0] % 101;
      u_meas.fault(lf, ed, lf[7], st);
      q.push_front({st, lf[7], ed, lf});
      if (q.size() > 8) void'(q.pop_back());
    end
    rc(`MSPP_A_LOGCNT, 32'h8);
    for (i = 0; i < 8; i++) begin
      wr(`MSPP_A_LOGSEL, i);
      rc(`MSPP_A_LOGDATE, q[i][82:51]);
      rc(`MSPP_A_LOGTIME, {5'h0, q[i][50:24]});
      rc(`MSPP_A_LOGINFO, {8'h0, q[i][23:0]});
    end
    // Force flag: a button press restarts its timeout.
    wr(`MSPP_A_CTRL, 32'h2); repeat (2) @(posedge mclk); #1; chk("force", test_force, 1);
    repeat (40) @(posedge mclk);
    panel_button <= 1'b1;
    repeat (3) @(posedge mclk);
    panel_button <= 1'b0;
    repeat (65) @(posedge mclk); #1; chk("force", test_force, 1);
    repeat (30) @(posedge mclk); #1; chk("force", test_force, 0);
    stop_test;
  end
endmodule // testbench
bind mspp_top mspp_checker u_chk (.mclk(mclk), .reset(reset), .hsel(hsel), .htrans(htrans),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .fund_current(fund_current),
  .neg_pos_sequence_ratio(neg_pos_sequence_ratio), .motor_starting(motor_starting),
  .pr_start(pr_start), .pr_trip(pr_trip), .stall_start(stall_start), .stall_trip(stall_trip));
`default_nettype wire

// >>> logic/mspp_defs.vh
// Constants of the motor stall and phase sequence protection block.
`ifndef MSPP_DEFS_VH
`define MSPP_DEFS_VH
// ==========================================================
// Register byte offsets
`define MSPP_A_CTRL 8'h00
`define MSPP_A_RSTART 8'h04
`define MSPP_A_STDET 8'h08
`define MSPP_A_MOTNOM 8'h0c
`define MSPP_A_STDETA 8'h10
`define MSPP_A_TDEF 8'h14
`define MSPP_A_INVERSE_TIME_MULTIPLIER 8'h18
`define MSPP_A_STAT 8'h1c
`define MSPP_A_MASK 8'h20
`define MSPP_A_PRCNT 8'h24
`define MSPP_A_STCNT 8'h28
`define MSPP_A_ELAPSED_DELAY_PCT 8'h2c
`define MSPP_A_LOGCNT 8'h30
`define MSPP_A_LOGSEL 8'h34
`define MSPP_A_LOGDATE 8'h38
`define MSPP_A_LOGTIME 8'h3c
`define MSPP_A_LOGINFO 8'h40
// ==========================================================
// Field positions
`define MSPP_CTRL_INV 0
`define MSPP_CTRL_FORCE 1
`define MSPP_ST_PRS 0
`define MSPP_ST_PRT 1
`define MSPP_ST_SLS 2
`define MSPP_ST_SLT 3
`define MSPP_ST_LOG 4
// ==========================================================
// Reset values, currents in hundredths of motor nominal
`define MSPP_RST_RSTART 16'h0258
`define MSPP_RST_STDET 16'h012c
`define MSPP_RST_MOTNOM 16'h0064
`define MSPP_RST_TDEF 16'h2710
`define MSPP_RST_INVERSE_TIME_MULTIPLIER 16'h2710
`define MSPP_RST_MASK 5'h00
// ==========================================================
// Levels
`define MSPP_LOW_LVL 16'h000a
`define MSPP_REL_LVL 16'h0078
`define MSPP_PR_AVG 16'h0014
`define MSPP_PR_RATIO 8'h50
// ==========================================================
// Timing
// Counts are sized to the parameters they feed; 10 MHz gives 10000 cycles a millisecond.
`define MSPP_MS_CYCLES 14'h2710
`define MSPP_PR_MS 16'h0064
`define MSPP_WIN_MS 16'h00c8
// Five minutes of milliseconds for the shared test flag.
`define MSPP_FORCE_MS 19'h493e0
`endif

// >>> logic/mspp_top.v
// Stall, phase reversal and unbalance fault log logic with an AHB-Lite slave.
`timescale 1ns/10ps
`default_nettype none
`include "mspp_defs.vh"

// Summary of operation
// - Keep the eight newest unbalance fault records, overwriting the oldest.
// - A record stamps date year-month-day and time to milliseconds.
// - Elapsed delay is percent of operating time, one hundred at trip.
// - A record notes which of two setting groups was active.
// - Reversal start only at start-up, ratio above 80%, average above 0.2.
// - Reversal trip follows 100 ms after its start.
// - Start and trip counters count each rising edge of their output.
// - Stall compares only fundamental frequency current.
// - Stall time is definite or inverse, selectable.
// - Inverse time is start time times squared start-to-measured ratio.
// - Rated start current resets to 6.00 times nominal.
// - Stall times only after current below 10% rose past level in 200 ms.
// - Stall releases below 120% of nominal, clearing start and timer.
// - Stall works only while starting; outputs idle otherwise.
// - One shared test flag clears 5 minutes after last button press.
// - Start detection level in primary amperes is computed, read only.
module mspp_top #(
  parameter [13:0] P_MS_CYCLES = `MSPP_MS_CYCLES,
  parameter [15:0] P_PR_MS = `MSPP_PR_MS,
  parameter [15:0] P_WIN_MS = `MSPP_WIN_MS,
  parameter [18:0] P_FORCE_MS = `MSPP_FORCE_MS
) (
  input wire mclk,
  input wire reset,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [15:0] fund_current,
  input wire [7:0] neg_pos_sequence_ratio,
  input wire motor_starting,
  input wire panel_button,
  input wire unb_fault,
  input wire [15:0] unb_peak,
  input wire [6:0] unb_elapsed_delay_pct,
  input wire active_setting_group,
  input wire [31:0] rtc_date,
  input wire [26:0] rtc_time,
  output reg pr_start,
  output reg pr_trip,
  output reg stall_start,
  output reg stall_trip,
  output reg test_force,
  output reg irq
);

  // ==========================================================
  // Bus slave state
  reg pend;
  reg pend_wr;
  reg [7:0] pend_addr;
  reg inv_mode;
  reg [15:0] rated_start_current;
  reg [15:0] st_det;
  reg [15:0] mot_nom;
  reg [15:0] st_det_amps;
  reg [15:0] t_def;
  reg [15:0] inverse_time_multiplier;
  reg [4:0] status;
  reg [4:0] mask;
  reg [2:0] log_sel;
  wire wr_go;
  assign wr_go = pend && pend_wr;

  // ==========================================================
  // Protection state
  reg [13:0] div_cnt;
  reg ms_tick;
  reg btn_s1;
  reg btn_s2;
  reg btn_s3;
  reg btn_stable;
  reg [18:0] force_ms;
  reg armed;
  reg [15:0] win_ms;
  reg [47:0] acc;
  reg [55:0] mark;
  reg [6:0] stall_pct;
  reg [15:0] pr_ms;
  reg [6:0] pr_pct;
  reg [15:0] prs_cnt;
  reg [15:0] prt_cnt;
  reg [15:0] sls_cnt;
  reg [15:0] slt_cnt;
  reg pr_start_d;
  reg pr_trip_d;
  reg stall_start_d;
  reg stall_trip_d;
  reg [31:0] log_date [0:7];
  reg [26:0] log_time [0:7];
  reg [23:0] log_info [0:7];
  reg [2:0] log_wp;
  reg [3:0] log_cnt;

  // ==========================================================
  // Derived terms
  wire [31:0] cur_sq;
  wire [31:0] rst_sq;
  wire [47:0] inv_target;
  wire [47:0] target;
  wire [47:0] step;
  wire [55:0] acc100;
  wire [2:0] rd_idx;
  wire pr_cond;
  wire stall_rel;
  wire btn_press;
  wire [23:0] pr_prod;
  wire [31:0] det_prod;
  wire [23:0] pr_frac;
  wire [31:0] det_amps;
  wire [4:0] events;
  // Squares are used so that trip happens when the integral of I^2 reaches Tstart*Ist^2,
  // which avoids a divider and also tracks a sagging start current.
  assign cur_sq = fund_current * fund_current;
  assign rst_sq = rated_start_current * rated_start_current;
  assign inv_target = inverse_time_multiplier * rst_sq;
  assign target = inv_mode ? inv_target : {32'h00000000, t_def};
  assign step = inv_mode ? {16'h0000, cur_sq} : 48'h000000000001;
  assign acc100 = {2'b00, acc, 6'b000000} + {3'b000, acc, 5'b00000}
    + {6'b000000, acc, 2'b00};
  assign rd_idx = log_wp - 3'h1 - log_sel;
  assign pr_cond = motor_starting && (neg_pos_sequence_ratio > `MSPP_PR_RATIO)
    && (fund_current > `MSPP_PR_AVG);
  assign stall_rel = !motor_starting || (fund_current < `MSPP_REL_LVL);
  assign btn_press = (btn_s2 == btn_s3) && btn_s3 && !btn_stable;
  assign pr_prod = pr_ms[15:0] * 8'h64;
  assign det_prod = st_det * mot_nom;
  // Below the trip point the quotient stays under one hundred, so seven bits hold it.
  assign pr_frac = pr_prod / {8'h00, P_PR_MS};
  assign det_amps = det_prod / 32'h00000064;
  assign events = {unb_fault, stall_trip & ~stall_trip_d,
    stall_start & ~stall_start_d, pr_trip & ~pr_trip_d, pr_start & ~pr_start_d};

  // ==========================================================
  // Millisecond enable from the system clock.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      div_cnt <= 14'h0000;
      ms_tick <= 1'b0;
    end else if (div_cnt >= P_MS_CYCLES - 14'h0001) begin
      div_cnt <= 14'h0000;
      ms_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 14'h0001;
      ms_tick <= 1'b0;
    end
  end

  // Button pin passes three flops; a press counts once the last two agree.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      btn_s1 <= 1'b0;
      btn_s2 <= 1'b0;
      btn_s3 <= 1'b0;
      btn_stable <= 1'b0;
    end else begin
      btn_s1 <= panel_button;
      btn_s2 <= btn_s1;
      btn_s3 <= btn_s2;
      if (btn_s2 == btn_s3) begin
        btn_stable <= btn_s3;
      end
    end
  end

  // Shared test flag; a press or a software set restarts the five minute timeout.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      test_force <= 1'b0;
      force_ms <= 19'h00000;
    end else if (wr_go && pend_addr == `MSPP_A_CTRL) begin
      test_force <= hwdata[`MSPP_CTRL_FORCE];
      force_ms <= 19'h00000;
    end else if (btn_press) begin
      force_ms <= 19'h00000;
    end else if (test_force && ms_tick) begin
      if (force_ms >= P_FORCE_MS - 19'h00001) begin
        test_force <= 1'b0;
        force_ms <= 19'h00000;
      end else begin
        force_ms <= force_ms + 19'h00001;
      end
    end
  end

  // ==========================================================
  // Phase reversal stage: timer runs from the start and clears when the condition drops.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      pr_start <= 1'b0;
      pr_trip <= 1'b0;
      pr_ms <= 16'h0000;
      pr_pct <= 7'h00;
    end else if (!pr_cond) begin
      pr_start <= 1'b0;
      pr_trip <= 1'b0;
      pr_ms <= 16'h0000;
    end else begin
      pr_start <= 1'b1;
      if (ms_tick && pr_ms < P_PR_MS) begin
        pr_ms <= pr_ms + 16'h0001;
      end
      if (pr_ms >= P_PR_MS) begin
        pr_trip <= 1'b1;
      end
      pr_pct <= (pr_ms >= P_PR_MS) ? 7'h64 : pr_frac[6:0];
    end
  end

  // ==========================================================
  // Arming: the current must have been low, then the rise must come within the window.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      armed <= 1'b0;
      win_ms <= 16'h0000;
    end else if (fund_current < `MSPP_LOW_LVL) begin
      armed <= 1'b1;
      win_ms <= 16'h0000;
    end else if (armed && ms_tick) begin
      if (win_ms >= P_WIN_MS) begin
        armed <= 1'b0;
      end else begin
        win_ms <= win_ms + 16'h0001;
      end
    end
  end

  // Stall stage: acc integrates one per ms (definite) or I^2 per ms (inverse) up to target.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      stall_start <= 1'b0;
      stall_trip <= 1'b0;
      acc <= 48'h000000000000;
      mark <= 56'h00000000000000;
      stall_pct <= 7'h00;
    end else if (stall_rel) begin
      stall_start <= 1'b0;
      stall_trip <= 1'b0;
      acc <= 48'h000000000000;
      stall_pct <= 7'h00;
      mark <= {8'h00, target};
    end else if (!stall_start) begin
      if (armed && fund_current > st_det) begin
        stall_start <= 1'b1;
      end
      mark <= {8'h00, target};
    end else begin
      if (ms_tick && acc < target) begin
        acc <= acc + step;
      end
      if (acc >= target) begin
        stall_trip <= 1'b1;
      end
      // Percent catches up one step per cycle, far faster than acc moves with the default 10000-cycle millisecond.
      if (stall_pct < 7'h64 && acc100 >= mark) begin
        stall_pct <= stall_pct + 7'h01;
        mark <= mark + {8'h00, target};
      end
    end
  end

  // ==========================================================
  // Counters advance on rising edges of each output.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      pr_start_d <= 1'b0;
      pr_trip_d <= 1'b0;
      stall_start_d <= 1'b0;
      stall_trip_d <= 1'b0;
      prs_cnt <= 16'h0000;
      prt_cnt <= 16'h0000;
      sls_cnt <= 16'h0000;
      slt_cnt <= 16'h0000;
    end else begin
      pr_start_d <= pr_start;
      pr_trip_d <= pr_trip;
      stall_start_d <= stall_start;
      stall_trip_d <= stall_trip;
      if (events[`MSPP_ST_PRS]) begin
        prs_cnt <= prs_cnt + 16'h0001;
      end
      if (events[`MSPP_ST_PRT]) begin
        prt_cnt <= prt_cnt + 16'h0001;
      end
      if (events[`MSPP_ST_SLS]) begin
        sls_cnt <= sls_cnt + 16'h0001;
      end
      if (events[`MSPP_ST_SLT]) begin
        slt_cnt <= slt_cnt + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Fault log ring; the write pointer passes the oldest entry first.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      log_wp <= 3'h0;
      log_cnt <= 4'h0;
    end else if (unb_fault) begin
      log_wp <= log_wp + 3'h1;
      if (log_cnt < 4'h8) begin
        log_cnt <= log_cnt + 4'h1;
      end
    end
  end

  // Entry storage has no reset; unused entries are not masked on read, only the count tells which are valid.
  always @(posedge mclk) begin
    if (unb_fault) begin
      log_date[log_wp] <= rtc_date;
      log_time[log_wp] <= rtc_time;
      log_info[log_wp] <= {active_setting_group, unb_elapsed_delay_pct, unb_peak};
    end
  end

  // ==========================================================
  // Configuration registers and the primary ampere level.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      inv_mode <= 1'b0;
      rated_start_current <= `MSPP_RST_RSTART;
      st_det <= `MSPP_RST_STDET;
      mot_nom <= `MSPP_RST_MOTNOM;
      t_def <= `MSPP_RST_TDEF;
      inverse_time_multiplier <= `MSPP_RST_INVERSE_TIME_MULTIPLIER;
      mask <= `MSPP_RST_MASK;
      log_sel <= 3'h0;
      st_det_amps <= 16'h0000;
    end else begin
      st_det_amps <= det_amps[15:0];
      if (wr_go) begin
        case (pend_addr)
          `MSPP_A_CTRL: inv_mode <= hwdata[`MSPP_CTRL_INV];
          `MSPP_A_RSTART: rated_start_current <= hwdata[15:0];
          `MSPP_A_STDET: st_det <= hwdata[15:0];
          `MSPP_A_MOTNOM: mot_nom <= hwdata[15:0];
          `MSPP_A_TDEF: t_def <= hwdata[15:0];
          `MSPP_A_INVERSE_TIME_MULTIPLIER: inverse_time_multiplier <= hwdata[15:0];
          `MSPP_A_MASK: mask <= hwdata[4:0];
          `MSPP_A_LOGSEL: log_sel <= hwdata[2:0];
          default: ;
        endcase
      end
    end
  end

  // Sticky status; a new event in the clearing cycle survives the clear.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      status <= 5'h00;
      irq <= 1'b0;
    end else begin
      if (wr_go && pend_addr == `MSPP_A_STAT) begin
        status <= (status & ~hwdata[4:0]) | events;
      end else begin
        status <= status | events;
      end
      irq <= |(status & mask);
    end
  end

  // ==========================================================
  // AHB-Lite slave with one wait state so read data comes from a flop.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      pend <= 1'b0;
      pend_wr <= 1'b0;
      pend_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else if (pend) begin
      pend <= 1'b0;
      hreadyout <= 1'b1;
      if (!pend_wr) begin
        case (pend_addr)
          `MSPP_A_CTRL: hrdata <= {30'h00000000, test_force, inv_mode};
          `MSPP_A_RSTART: hrdata <= {16'h0000, rated_start_current};
          `MSPP_A_STDET: hrdata <= {16'h0000, st_det};
          `MSPP_A_MOTNOM: hrdata <= {16'h0000, mot_nom};
          `MSPP_A_STDETA: hrdata <= {16'h0000, st_det_amps};
          `MSPP_A_TDEF: hrdata <= {16'h0000, t_def};
          `MSPP_A_INVERSE_TIME_MULTIPLIER: hrdata <= {16'h0000, inverse_time_multiplier};
          `MSPP_A_STAT: hrdata <= {27'h0000000, status};
          `MSPP_A_MASK: hrdata <= {27'h0000000, mask};
          `MSPP_A_PRCNT: hrdata <= {prt_cnt, prs_cnt};
          `MSPP_A_STCNT: hrdata <= {slt_cnt, sls_cnt};
          `MSPP_A_ELAPSED_DELAY_PCT: hrdata <= {9'h000, stall_pct, 9'h000, pr_pct};
          `MSPP_A_LOGCNT: hrdata <= {28'h0000000, log_cnt};
          `MSPP_A_LOGSEL: hrdata <= {29'h00000000, log_sel};
          `MSPP_A_LOGDATE: hrdata <= log_date[rd_idx];
          `MSPP_A_LOGTIME: hrdata <= {5'h00, log_time[rd_idx]};
          `MSPP_A_LOGINFO: hrdata <= {8'h00, log_info[rd_idx]};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end else if (hsel && htrans[1] && hready) begin
      pend <= 1'b1;
      pend_wr <= hwrite;
      pend_addr <= {haddr[7:2], 2'b00};
      hreadyout <= 1'b0;
    end
  end

endmodule // mspp_top
`default_nettype wire
